/* shared/temp_sensor_defs.vh */
/*
  Constants of the temperature conversion block: result layout, reset
  values, command codes, configuration fields and bus timing counts.
  Assumes a 100 MHz clock; time figures are kept in their own unit and
  converted to cycles here.
*/
`ifndef TEMP_SENSOR_DEFS_VH
`define TEMP_SENSOR_DEFS_VH

`define CLK_MHZ            100
// Result register
`define RESULT_RESET       16'h0550
`define RESULT_W           16
`define RAW_W              12
// Commands
`define CMD_CONVERT        8'h44
`define CMD_WRITE_CFG      8'h4e
`define CMD_READ_RESULT    8'hbe
`define CMD_COPY_NV        8'h48
// Configuration register: resolution field and location field
`define CFG_RES_LSB        5
`define CFG_RES_MSB        6
`define CFG_LOC_LSB        0
`define CFG_LOC_MSB        3
`define RES_9              2'h0
`define RES_10             2'h1
`define RES_11             2'h2
`define RES_12             2'h3
`define CFG_RESET_RES      2'h3
// Conversion times in microseconds
`define CONV9_US           93750
`define CONV10_US          187500
`define CONV11_US          375000
`define CONV12_US          750000
`define NV_WRITE_TYP_US    2000
`define NV_WRITE_MAX_US    10000
// Slot timing in microseconds
`define SLOT_MIN_US        60
`define SLOT_MAX_US        120
`define REC_MIN_US         1
`define LOW1_MAX_US        15
`define READ_VALID_US      15
`define SAMPLE_US          30
`define RESET_LOW_MIN_US   480
`define RESET_HIGH_MIN_US  480
`define POR_LOW_US         960
`define PRES_WAIT_US       30
`define PRES_PULSE_US      120
// Derived cycle counts
`define CYC(us)            ((us) * `CLK_MHZ)
`define SAMPLE_CYC         `CYC(`SAMPLE_US)
`define RESET_LOW_CYC      `CYC(`RESET_LOW_MIN_US)
`define POR_LOW_CYC        `CYC(`POR_LOW_US)
`define PRES_WAIT_CYC      `CYC(`PRES_WAIT_US)
`define PRES_PULSE_CYC     `CYC(`PRES_PULSE_US)
`define READ_HOLD_CYC      `CYC(`SAMPLE_US)
`define NV_WRITE_CYC       `CYC(`NV_WRITE_TYP_US)

`endif

/* hw/conv_timer.v */
/*
  Conversion timer: counts the conversion time for the chosen
  resolution and pulses done at its end.
  Assumes the caller starts it only while it is idle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "temp_sensor_defs.vh"

module conv_timer #(
  parameter CONV9_CYC = `CYC(`CONV9_US)
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clkEn,
  input  wire        start,
  input  wire [1:0]  res,
  output reg         busy_r,
  output reg         done_r
);
  reg [31:0] count_r;

  // ----------------------------------------
  // Each step of resolution doubles the time
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 32'h0;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else if (clkEn) begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        count_r <= (CONV9_CYC << res) - 1;
        busy_r  <= 1'b1;
      end else if (busy_r) begin
        if (count_r == 32'h0) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          count_r <= count_r - 32'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* hw/temp_sensor_conversion.v */
/*
  Device side of the single-line thermometer: slot decoder for the bus
  line, reset/presence answer, command byte intake, conversion control,
  result register, configuration and read-back shifter.
  Assumes the line input is already synchronous to clk and that the
  analogue front end presents a 12-bit reading on sensorValue.
*/
`timescale 1ns/1ps
`default_nettype none
`include "temp_sensor_defs.vh"

module temp_sensor_conversion #(
  parameter CONV9_CYC = `CYC(`CONV9_US),
  parameter NV_CYC    = `NV_WRITE_CYC
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clkEn,
  input  wire        lineIn,
  output reg         lineOut,
  output reg         lineOe,
  input  wire        busPowered,
  input  wire [11:0] sensorValue,
  input  wire        locationPinLsb,
  input  wire        locationPin1,
  input  wire        locationPin2,
  input  wire        locationPinMsb,
  output reg  [15:0] temperatureResult_r,
  output reg  [7:0]  config_r,
  output reg         converting_r,
  output reg         nvBusy_r,
  output reg         porRequest_r
);
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_WAIT  = 5'h02;
  localparam [4:0] ST_PRES  = 5'h04;
  localparam [4:0] ST_SLOT  = 5'h08;
  localparam [4:0] ST_HOLD  = 5'h10;

  reg  [4:0]  state_r;
  reg  [31:0] cnt_r;
  reg         linePrev_r;
  reg  [7:0]  shiftIn_r;
  reg  [3:0]  bitCnt_r;
  reg  [1:0]  phase_r;
  reg  [15:0] shiftOut_r;
  reg         readMode_r;
  reg  [7:0]  limitHigh_r;
  reg  [7:0]  limitLow_r;
  reg  [31:0] nvCnt_r;
  reg         startConv;
  wire        convBusy;
  wire        convDone;
  wire        fallEdge = linePrev_r & ~lineIn;
  wire        riseEdge = ~linePrev_r & lineIn;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Clear the bits that the chosen resolution leaves undefined
  function [15:0] format_result;
    input [11:0] raw;
    input [1:0]  res;
    reg   [15:0] ext;
    begin
      ext = {{4{raw[11]}}, raw};
      // Four resolutions, 9 to 12 bits
      case (res)
        `RES_9:  format_result = {ext[15:3], 3'h0};
        `RES_10: format_result = {ext[15:2], 2'h0};
        `RES_11: format_result = {ext[15:1], 1'h0};
        default: format_result = ext;
      endcase
    end
  endfunction

  conv_timer #(
    .CONV9_CYC (CONV9_CYC)
  ) u_timer (
    .clk    (clk),
    .rst_n  (rst_n),
    .clkEn  (clkEn),
    .start  (startConv),
    .res    (config_r[`CFG_RES_MSB:`CFG_RES_LSB]),
    .busy_r (convBusy),
    .done_r (convDone)
  );

  // ----------------------------------------
  // Line state machine
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ST_IDLE;
      cnt_r        <= 32'h0;
      linePrev_r   <= 1'b1;
      shiftIn_r    <= 8'h0;
      bitCnt_r     <= 4'h0;
      phase_r      <= 2'h0;
      shiftOut_r   <= 16'h0;
      readMode_r   <= 1'b0;
      lineOut      <= 1'b0;
      lineOe       <= 1'b0;
      startConv    <= 1'b0;
      porRequest_r <= 1'b0;
      config_r     <= {1'b0, `CFG_RESET_RES, 5'h0};
      limitHigh_r  <= 8'h0;
      limitLow_r   <= 8'h0;
      nvBusy_r     <= 1'b0;
      nvCnt_r      <= 32'h0;
    end else if (clkEn) begin
      linePrev_r <= lineIn;
      startConv  <= 1'b0;
      config_r[`CFG_LOC_MSB:`CFG_LOC_LSB] <=
        {locationPinMsb, locationPin2, locationPin1, locationPinLsb};
      if (nvBusy_r) begin
        if (nvCnt_r == 32'h0)
          nvBusy_r <= 1'b0;
        else
          nvCnt_r <= nvCnt_r - 32'h1;
      end
      if (!lineIn)
        cnt_r <= cnt_r + 32'h1;
      // Long low is a bus reset
      if (riseEdge && cnt_r >= `RESET_LOW_CYC) begin
        porRequest_r <= busPowered && cnt_r > `POR_LOW_CYC;
        state_r  <= ST_WAIT;
        cnt_r    <= 32'h0;
        phase_r  <= 2'h0;
        bitCnt_r <= 4'h0;
        lineOe   <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (fallEdge) begin
              cnt_r   <= 32'h0;
              state_r <= ST_SLOT;
            end
          end
          ST_WAIT: begin
            cnt_r <= cnt_r + 32'h1;
            if (cnt_r == `PRES_WAIT_CYC - 1) begin
              cnt_r   <= 32'h0;
              lineOe  <= 1'b1;
              state_r <= ST_PRES;
            end
          end
          ST_PRES: begin
            cnt_r <= cnt_r + 32'h1;
            if (cnt_r == `PRES_PULSE_CYC - 1) begin
              cnt_r   <= 32'h0;
              lineOe  <= 1'b0;
              state_r <= ST_IDLE;
            end
          end
          ST_SLOT: begin
            cnt_r <= cnt_r + 32'h1;
            if (cnt_r == 32'h0 && phase_r == 2'h2) begin
              lineOe <= readMode_r ? ~shiftOut_r[0] : ~(converting_r == 1'b0);
              state_r <= ST_HOLD;
            end else if (cnt_r == `SAMPLE_CYC - 1) begin
              shiftIn_r <= {lineIn, shiftIn_r[7:1]};
              bitCnt_r  <= bitCnt_r + 4'h1;
              state_r   <= ST_IDLE;
              if (bitCnt_r == 4'h7) begin
                bitCnt_r <= 4'h0;
                case (phase_r)
                  2'h0: phase_r <= 2'h1;
                  2'h1: begin
                    if ({lineIn, shiftIn_r[7:1]} == `CMD_CONVERT) begin
                      startConv  <= 1'b1;
                      readMode_r <= 1'b0;
                      phase_r    <= 2'h2;
                    end else if ({lineIn, shiftIn_r[7:1]} == `CMD_READ_RESULT) begin
                      shiftOut_r <= temperatureResult_r;
                      readMode_r <= 1'b1;
                      phase_r    <= 2'h2;
                    end else if ({lineIn, shiftIn_r[7:1]} == `CMD_COPY_NV) begin
                      nvBusy_r <= 1'b1;
                      nvCnt_r  <= NV_CYC - 1;
                      phase_r  <= 2'h0;
                    end else if ({lineIn, shiftIn_r[7:1]} == `CMD_WRITE_CFG) begin
                      phase_r  <= 2'h3;
                      bitCnt_r <= 4'h0;
                    end
                  end
                  default: begin
                    // Config write: every byte sets the resolution bits while readMode_r is clear; limits take old low limit and config
                    if (readMode_r == 1'b0 && phase_r == 2'h3) begin
                      limitHigh_r <= limitLow_r;
                      limitLow_r  <= config_r;
                      // Completed byte is {lineIn, shiftIn_r[7:1]}, so its bits 6:5 sit one up
                      config_r[`CFG_RES_MSB:`CFG_RES_LSB] <= shiftIn_r[7:6];
                    end
                  end
                endcase
              end
            end
          end
          ST_HOLD: begin
            cnt_r <= cnt_r + 32'h1;
            if (cnt_r == `READ_HOLD_CYC - 1) begin
              lineOe     <= 1'b0;
              shiftOut_r <= {1'b1, shiftOut_r[15:1]};
              state_r    <= ST_IDLE;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Conversion result
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temperatureResult_r <= `RESULT_RESET;
      converting_r        <= 1'b0;
    end else if (clkEn) begin
      if (startConv)
        converting_r <= 1'b1;
      else if (convDone)
        converting_r <= 1'b0;
      if (convDone) begin
        temperatureResult_r <=
          format_result(sensorValue, config_r[`CFG_RES_MSB:`CFG_RES_LSB]);
      end
    end
  end
endmodule
`default_nettype wire

/* verif/bus_master_model.sv */
/* Bus master model: reset pulse, write and read slots on the line.
   Assumes the bench resolves the open-drain line and feeds lineIn. */
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input  wire logic clk,
  input  wire logic lineIn,
  output var  logic masterLow
);
  initial masterLow = 1'b0;
  task automatic holdLow(input int lowCyc, input int highCyc);
    @(posedge clk);
    masterLow <= 1'b1;
    repeat (lowCyc) @(posedge clk);
    masterLow <= 1'b0;
    repeat (highCyc) @(posedge clk);
  endtask
  task automatic writeByte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      holdLow(v[i] ? 100 : 6000, v[i] ? 6000 : 100);
    end
  endtask
  task automatic readBit(output logic b);
    holdLow(100, 1200);
    b = lineIn;
    repeat (4800) @(posedge clk);
  endtask
  task automatic busReset(output logic pres);
    holdLow(48100, 7000);
    pres = ~lineIn;
    repeat (41100) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* verif/temp_sensor_conversion_assertions.sv */
/* Checker on the conversion block's ports.
   Assumes one clock and a pulled-up line seen on lineIn. */
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_checker #(
  parameter CONV9_CYC = 100
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        clkEn,
  input wire logic        lineIn,
  input wire logic        lineOe,
  input wire logic [11:0] sensorValue,
  input wire logic        locationPinLsb,
  input wire logic        locationPin1,
  input wire logic        locationPin2,
  input wire logic        locationPinMsb,
  input wire logic [15:0] temperatureResult_r,
  input wire logic [7:0]  config_r,
  input wire logic        converting_r
);
  logic [15:0] highRun_r;
  logic [15:0] lowRun_r;
  logic [15:0] oeRun_r;
  logic [31:0] convRun_r;
  logic        presFlag_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Run lengths
  // ----------------------------------------
  // The 16-bit runs saturate, so a long reset pulse cannot wrap into a short one
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      highRun_r <= 16'h0;
      lowRun_r <= 16'h0;
      oeRun_r <= 16'h0;
      convRun_r <= 32'h0;
      presFlag_r <= 1'b0;
    end else begin
      highRun_r <= lineIn ? highRun_r + {15'h0, highRun_r != 16'hffff} : 16'h0;
      lowRun_r <= !lineIn ? lowRun_r + {15'h0, lowRun_r != 16'hffff} : 16'h0;
      oeRun_r <= lineOe ? oeRun_r + {15'h0, oeRun_r != 16'hffff} : 16'h0;
      convRun_r <= converting_r ? convRun_r + 32'h1 : 32'h0;
      if (lineOe && oeRun_r == 16'h0) begin
        presFlag_r <= (highRun_r != 16'h0);
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_POR_STATE: assert property (
    $rose(rst_n) |-> temperatureResult_r == 16'h0550 && config_r[6:5] == 2'h3)
    else $error("reset state wrong");
  AST_LOCATION: assert property (
    $past(rst_n) && $past(clkEn) |-> config_r[3:0] ==
      $past({locationPinMsb, locationPin2, locationPin1, locationPinLsb}))
    else $error("location field wrong");
  AST_RESULT_VALUE: assert property (
    $fell(converting_r) |->
      temperatureResult_r[15:3] ==
        {{4{$past(sensorValue[11])}}, $past(sensorValue[11:3])})
    else $error("result value wrong");
  AST_RESULT_STEP: assert property (
    !$stable(temperatureResult_r) |-> $fell(converting_r))
    else $error("result changed outside conversion end");
  AST_CONV_TIME: assert property (
    $fell(converting_r) |-> convRun_r <= (CONV9_CYC << config_r[6:5]) + 1)
    else $error("conversion too long");
  AST_PRES_WAIT: assert property (
    $rose(lineOe) && highRun_r != 16'h0 |-> highRun_r >= 16'd1500 && highRun_r <= 16'd6000)
    else $error("presence wait wrong");
  AST_PRES_LEN: assert property (
    $fell(lineOe) && presFlag_r |-> oeRun_r >= 16'd6000 && oeRun_r <= 16'd24000)
    else $error("presence length wrong");
  AST_READ_VALID: assert property (
    $rose(lineOe) && highRun_r == 16'h0 |-> lowRun_r < 16'd1500)
    else $error("read bit late");
  AST_BUSY_READ: assert property (
    converting_r && $fell(lineIn) |-> ##[1:3] lineOe)
    else $error("busy not answered");
endmodule
bind temp_sensor_conversion temp_sensor_checker #(.CONV9_CYC(CONV9_CYC)) chk (
  .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .lineIn(lineIn), .lineOe(lineOe),
  .sensorValue(sensorValue),
  .locationPinLsb(locationPinLsb), .locationPin1(locationPin1),
  .locationPin2(locationPin2), .locationPinMsb(locationPinMsb),
  .temperatureResult_r(temperatureResult_r), .config_r(config_r),
  .converting_r(converting_r));
`default_nettype wire

/* verif/temp_sensor_conversion_tb_top.sv */
/* Bench: reset state, bus reset, convert command, polls and result.
   Assumes the master model's slot timing and a shortened count. */
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_conversion_tb_top;
  logic        clk;
  logic        rst_n;
  logic [11:0] sensorValue;
  logic [3:0]  loc;
  logic        masterLow;
  logic        lineOut;
  logic        lineOe;
  logic [15:0] temperatureResult_r;
  logic [7:0]  config_r;
  logic        converting_r;
  logic        clkEn;
  logic        busPowered;
  logic        nvBusy_r;
  logic        porRequest_r;
  logic        b;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;
  wire         lineIn;
  // Open-drain line with pull-up
  assign lineIn = ~(masterLow | (lineOe & ~lineOut));
  // Shortened count: 12-bit conversion lasts 16000 cycles
  temp_sensor_conversion #(.CONV9_CYC(2000), .NV_CYC(50)) DUT (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .lineIn(lineIn), .lineOut(lineOut),
    .lineOe(lineOe), .busPowered(busPowered), .sensorValue(sensorValue),
    .locationPinLsb(loc[0]), .locationPin1(loc[1]), .locationPin2(loc[2]),
    .locationPinMsb(loc[3]), .temperatureResult_r(temperatureResult_r),
    .config_r(config_r), .converting_r(converting_r), .nvBusy_r(nvBusy_r),
    .porRequest_r(porRequest_r));
  bus_master_model master (.clk(clk), .lineIn(lineIn), .masterLow(masterLow));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic settle;
    @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    // Bus reset plus sixteen write slots dominate: about 213k cycles in all
    if (cycles == 250000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    busPowered = 1'b0;
    sensorValue = 12'he6f;
    loc = 4'ha;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    cmp(temperatureResult_r, 16'h0550);
    cmp({14'h0, config_r[6:5]}, 16'h3);
    cmp({15'h0, converting_r}, 16'h0);
    settle();
    cmp({12'h0, config_r[3:0]}, 16'ha);
    @(posedge clk);
    loc <= 4'h5;
    settle();
    settle();
    cmp({12'h0, config_r[3:0]}, 16'h5);
    // Enable low must freeze the location field
    @(posedge clk);
    clkEn <= 1'b0;
    loc <= 4'hc;
    settle();
    settle();
    cmp({12'h0, config_r[3:0]}, 16'h5);
    @(posedge clk);
    clkEn <= 1'b1;
    settle();
    settle();
    cmp({12'h0, config_r[3:0]}, 16'hc);
    // Bus-powered reset well under the limit: no power-on request
    @(posedge clk);
    busPowered <= 1'b1;
    master.busReset(b);
    cmp({15'h0, b}, 16'h1);
    cmp({15'h0, porRequest_r}, 16'h0);
    cmp({15'h0, nvBusy_r}, 16'h0);
    busPowered <= 1'b0;
    master.writeByte(8'h00);
    cmp({15'h0, converting_r}, 16'h0);
    master.writeByte(8'h44);
    cmp({15'h0, converting_r}, 16'h1);
    master.readBit(b);
    cmp({15'h0, b}, 16'h0);
    cmp(temperatureResult_r, 16'h0550);
    for (int i = 0; i < 20000 && converting_r !== 1'b0; i++) begin
      @(posedge clk);
    end
    #1;
    cmp(temperatureResult_r, 16'hfe6f);
    master.readBit(b);
    cmp({15'h0, b}, 16'h1);
    // Second reset in mid-run restores the power-on result
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    cmp(temperatureResult_r, 16'h0550);
    cmp({15'h0, converting_r}, 16'h0);
    settle();
    cmp({12'h0, config_r[3:0]}, 16'hc);
    summarize();
  end
endmodule
`default_nettype wire
